// *** core/smrp_pkg.sv ***
// shared constants and types for the measurement readout port
package smrp_pkg;
    localparam logic [7:0] CMD_CONFIG   = 8'hD0;
    localparam logic [7:0] CMD_RD_VOLT  = 8'h8B;
    localparam logic [7:0] CMD_RD_CURR  = 8'h8C;
    localparam logic [7:0] CMD_RD_POWER = 8'h96;
    localparam logic [6:0] SLAVE_ADDR   = 7'h2A; // arbitrary default address
    localparam logic [1:0] SEL_POWER    = 2'h0;
    localparam logic [1:0] SEL_VOLT     = 2'h1;
    localparam logic [1:0] SEL_CURR     = 2'h2;
    localparam int         SEL_MSB      = 7;
    localparam int         SEL_LSB      = 6;
    localparam int         FRAC_BITS    = 6;
    localparam logic [15:0] CFG_RESET   = 16'h0000;
    localparam logic [9:0]  FS_POS      = 10'h100;
    localparam logic [9:0]  FS_NEG      = 10'h300;

    typedef enum logic [2:0] {
        SM_IDLE = 3'h0,
        SM_ADDR = 3'h1,
        SM_AACK = 3'h3,
        SM_RX   = 3'h2,
        SM_RACK = 3'h6,
        SM_TX   = 3'h7,
        SM_TACK = 3'h5
    } smrp_state_e;

    typedef struct packed {
        logic [9:0] voltage;
        logic [9:0] current;
        logic [9:0] power;
    } smrp_meas_s;
endpackage : smrp_pkg

// *** core/smrp_port.sv ***
// smbus slave exposing configuration word and measurement result
// Operation
// - result loads quantity chosen by selection
// - full scale 0x4000, negative 0xC000
// - sign plus nine bits, six zeros
// - one result register for all three measurement read codes
// - config D0 write and read, low first
// - 0x8B reads result, low byte first
// - 0x8C reads result, low byte first
// - 0x96 reads result, low byte first
// - selection bits 7:6, power default
// - selection applies from the next meas_valid sample, which loads the quantity selected at that time
`timescale 1ns/1ps
module smrp_port (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    input  wire smrp_pkg::smrp_meas_s meas,
    input  wire logic              meas_valid,
    output logic [15:0]            config_word,
    output logic [15:0]            result
);
    logic [2:0]  scl_sy_ff, sda_sy_ff;
    logic        scl_ff, sda_ff;
    smrp_pkg::smrp_state_e st_ff, nxt_st;
    logic [7:0]  sh_ff;
    logic [3:0]  bit_ff;
    logic [1:0]  byte_ff;
    logic        rd_ff;
    logic [7:0]  cmd_ff;
    logic [7:0]  lo_ff;
    logic [15:0] cfg_ff, res_ff;
    logic        oe_ff, nack_ff;
    logic        sda_o_ff;

    wire scl_ok   = scl_sy_ff[1] == scl_sy_ff[2];
    wire sda_ok   = sda_sy_ff[1] == sda_sy_ff[2];
    wire scl_now  = scl_ok ? scl_sy_ff[2] : scl_ff;
    wire sda_now  = sda_ok ? sda_sy_ff[2] : sda_ff;
    wire scl_rise = scl_now & ~scl_ff;
    wire scl_fall = ~scl_now & scl_ff;
    wire start_c  = scl_ff & scl_now & sda_ff & ~sda_now;
    wire stop_c   = scl_ff & scl_now & ~sda_ff & sda_now;
    wire [7:0] rx_byte = {sh_ff[6:0], sda_now};
    wire addr_hit = rx_byte[7:1] == smrp_pkg::SLAVE_ADDR;
    // all three read codes map to the same register
    wire is_read_cmd = cmd_ff == smrp_pkg::CMD_RD_VOLT || cmd_ff == smrp_pkg::CMD_RD_CURR
                    || cmd_ff == smrp_pkg::CMD_RD_POWER;
    wire is_cfg_cmd  = cmd_ff == smrp_pkg::CMD_CONFIG;
    wire [15:0] tx_word = is_cfg_cmd ? cfg_ff : res_ff;
    wire [1:0]  sel = cfg_ff[smrp_pkg::SEL_MSB:smrp_pkg::SEL_LSB];
    wire [9:0]  pick = sel == smrp_pkg::SEL_VOLT ? meas.voltage :
                       sel == smrp_pkg::SEL_CURR ? meas.current : meas.power;

    function automatic logic [15:0] fmt(input logic [9:0] v);
        fmt = {v, {smrp_pkg::FRAC_BITS{1'b0}}};
    endfunction : fmt

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_sy_ff <= 3'h7;
            sda_sy_ff <= 3'h7;
            scl_ff    <= 1'b1;
            sda_ff    <= 1'b1;
        end else begin
            scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
            sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
            scl_ff    <= scl_now;
            sda_ff    <= sda_now;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            smrp_pkg::SM_IDLE: nxt_st = st_ff;
            smrp_pkg::SM_ADDR: if (scl_rise && bit_ff == 4'h7)
                nxt_st = addr_hit ? smrp_pkg::SM_AACK : smrp_pkg::SM_IDLE;
            smrp_pkg::SM_AACK: if (scl_fall && bit_ff == 4'h9)
                nxt_st = rd_ff ? smrp_pkg::SM_TX : smrp_pkg::SM_RX;
            smrp_pkg::SM_RX:   if (scl_rise && bit_ff == 4'h7) nxt_st = smrp_pkg::SM_RACK;
            smrp_pkg::SM_RACK: if (scl_fall && bit_ff == 4'h9) nxt_st = smrp_pkg::SM_RX;
            smrp_pkg::SM_TX:   if (scl_fall && bit_ff == 4'h8) nxt_st = smrp_pkg::SM_TACK;
            smrp_pkg::SM_TACK: if (scl_fall)
                nxt_st = nack_ff ? smrp_pkg::SM_IDLE : smrp_pkg::SM_TX;
            default: nxt_st = smrp_pkg::SM_IDLE;
        endcase
        if (start_c) nxt_st = smrp_pkg::SM_ADDR;
        else if (stop_c) nxt_st = smrp_pkg::SM_IDLE;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff   <= smrp_pkg::SM_IDLE;
            sh_ff   <= 8'h00;
            bit_ff  <= 4'h0;
            byte_ff <= 2'h0;
            rd_ff   <= 1'b0;
            cmd_ff  <= 8'h00;
            lo_ff   <= 8'h00;
            oe_ff   <= 1'b0;
            nack_ff <= 1'b0;
            cfg_ff  <= smrp_pkg::CFG_RESET;
        end else begin
            st_ff <= nxt_st;
            if (start_c) begin
                bit_ff <= 4'h0;
                oe_ff  <= 1'b0;
            end else if (stop_c) begin
                oe_ff  <= 1'b0;
            end else case (st_ff)
                smrp_pkg::SM_ADDR, smrp_pkg::SM_RX: if (scl_rise) begin
                    sh_ff  <= rx_byte;
                    bit_ff <= bit_ff + 4'h1;
                    if (bit_ff == 4'h7 && st_ff == smrp_pkg::SM_ADDR) begin
                        rd_ff   <= rx_byte[0];
                        byte_ff <= 2'h0;
                    end
                    if (bit_ff == 4'h7 && st_ff == smrp_pkg::SM_RX) begin
                        byte_ff <= byte_ff + 2'h1;
                        if (byte_ff == 2'h0) cmd_ff <= rx_byte;
                        if (byte_ff == 2'h1) lo_ff <= rx_byte;
                        if (byte_ff == 2'h2 && is_cfg_cmd) cfg_ff <= {rx_byte, lo_ff};
                    end
                end
                // first fall: pull data low for the ack bit
                smrp_pkg::SM_AACK, smrp_pkg::SM_RACK: if (scl_fall && bit_ff == 4'h8) begin
                    oe_ff  <= 1'b1;
                    bit_ff <= 4'h9;
                end else if (scl_fall) begin
                    bit_ff <= 4'h0;
                    oe_ff  <= 1'b0;
                    if (rd_ff) begin
                        sh_ff <= tx_word[7:0];
                        oe_ff <= ~tx_word[7];
                        bit_ff <= 4'h1;
                    end
                end
                smrp_pkg::SM_TX: if (scl_fall) begin
                    if (bit_ff == 4'h8) begin
                        oe_ff <= 1'b0;
                        byte_ff <= byte_ff + 2'h1;
                    end else begin
                        oe_ff  <= ~sh_ff[7 - bit_ff[2:0]];
                        bit_ff <= bit_ff + 4'h1;
                    end
                end
                smrp_pkg::SM_TACK: if (scl_rise) nack_ff <= sda_now;
                else if (scl_fall && !nack_ff) begin
                    sh_ff  <= tx_word[15:8];
                    oe_ff  <= ~tx_word[15];
                    bit_ff <= 4'h1;
                end
                default: oe_ff <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_ff <= 16'h0000;
        end else if (meas_valid) begin
            res_ff <= fmt(pick);
        end
    end

    // open-drain: only ever drives low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_o_ff <= 1'b0;
        end else begin
            sda_o_ff <= 1'b0;
        end
    end

    AST_LOW_BITS_ZERO: assert property (@(posedge clk) disable iff (rst)
        res_ff[smrp_pkg::FRAC_BITS-1:0] == '0)
        else $error("result fraction bits not zero");
    AST_RES_LOAD: assert property (@(posedge clk) disable iff (rst)
        meas_valid |=> res_ff == fmt($past(pick)))
        else $error("result not loaded from selected quantity");
    AST_RES_HOLD: assert property (@(posedge clk) disable iff (rst)
        !meas_valid |=> $stable(res_ff))
        else $error("result changed without new sample");
    AST_CFG_ONLY_D0: assert property (@(posedge clk) disable iff (rst)
        $changed(cfg_ff) |-> $past(is_cfg_cmd))
        else $error("configuration written by other command");
    AST_RELEASE_ON_STOP: assert property (@(posedge clk) disable iff (rst)
        stop_c |=> !oe_ff)
        else $error("data line held after stop");
    AST_NO_DRIVE_IDLE: assert property (@(posedge clk) disable iff (rst)
        st_ff == smrp_pkg::SM_IDLE |=> !oe_ff)
        else $error("data line driven while idle");
    AST_TX_LOW_FIRST: assert property (@(posedge clk) disable iff (rst)
        (st_ff == smrp_pkg::SM_AACK && scl_fall && bit_ff == 4'h9 && rd_ff)
        |=> sh_ff == $past(tx_word[7:0]))
        else $error("read did not start with low byte");
    COV_CFG_WRITE: cover property (@(posedge clk) disable iff (rst) $changed(cfg_ff));
    COV_READ_NACK: cover property (@(posedge clk) disable iff (rst)
        st_ff == smrp_pkg::SM_TACK && scl_fall && nack_ff);
    COV_ADDR_MISS: cover property (@(posedge clk) disable iff (rst)
        st_ff == smrp_pkg::SM_ADDR && scl_rise && bit_ff == 4'h7 && !addr_hit);

    assign sda_o = sda_o_ff;
    assign sda_oe = oe_ff;
    assign config_word = cfg_ff;
    assign result = res_ff;
endmodule : smrp_port

// *** dv/smrp_host.sv ***
// behavioural smbus host for the readout port link
`timescale 1ns/1ps
module smrp_host (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial {scl, sda_low} = 2'b10;
    task automatic pb(input logic b, output logic s);
        sda_low = ~b;
        #40 scl = 1'b1;
        #40 s = sda;
        #40 scl = 1'b0;
        #40;
    endtask : pb
    task automatic cond(input logic st);
        sda_low = ~st;
        #40 scl = 1'b1;
        #80 sda_low = st;
        #80 scl = ~st;
        #40;
    endtask : cond
    task automatic xfer(input logic rd, input logic bad, input logic [7:0] c,
                        inout logic [15:0] d);
        logic [6:0]  a;
        logic [44:0] tx, rx;
        a = smrp_pkg::SLAVE_ADDR ^ {6'h0, bad};
        tx = rd ? {a, 2'b01, c, 1'b1, a, 2'b11, 8'hFF, 1'b0, 8'hFF, 1'b1}
                : {9'h0, a, 2'b01, c, 1'b1, d[7:0], 1'b1, d[15:8], 1'b1};
        cond(1'b1);
        for (int i = rd ? 44 : 35; i >= 0; i--) begin
            if (rd && i == 26) cond(1'b1);
            pb(tx[i], rx[i]);
        end
        cond(1'b0);
        d = rd ? {rx[8:1], rx[17:10]} : d;
    endtask : xfer
endmodule : smrp_host

// *** dv/smrp_port_tb.sv ***
// self-checking bench for the measurement readout port
`timescale 1ns/1ps
module smrp_port_tb;
    logic                 clk = 1'b0, rst = 1'b1, meas_valid = 1'b0;
    logic                 scl, sda_low, sda_o, sda_oe;
    logic [15:0]          config_word, result, got, cfg = 16'h0040;
    smrp_pkg::smrp_meas_s meas = '0;
    int                   num_errors = 0, num_checks = 0, seed = 58;
    wire                  sda = ~(sda_low | (sda_oe & ~sda_o));
    logic [7:0]           cmds [3] = '{smrp_pkg::CMD_RD_VOLT, smrp_pkg::CMD_RD_CURR,
                                       smrp_pkg::CMD_RD_POWER};
    always #5 clk = ~clk;
    smrp_port dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .meas(meas), .meas_valid(meas_valid), .config_word(config_word),
        .result(result));
    smrp_host host (.scl(scl), .sda_low(sda_low), .sda(sda));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD %0t %h %h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    function automatic logic [15:0] pick(input int s);
        return {(s == 1) ? meas.voltage : (s == 2) ? meas.current : meas.power, 6'h00};
    endfunction : pick
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        check(config_word, smrp_pkg::CFG_RESET);
        host.xfer(1'b0, 1'b1, smrp_pkg::CMD_CONFIG, cfg);
        check(config_word, smrp_pkg::CFG_RESET);
        for (int s = 0; s < 3; s++) begin
            cfg = (16'($random(seed)) & 16'hFF3F) | 16'(s << 6);
            host.xfer(1'b0, 1'b0, smrp_pkg::CMD_CONFIG, cfg);
            check(config_word, cfg);
            host.xfer(1'b1, 1'b0, smrp_pkg::CMD_CONFIG, got);
            check(got, cfg);
            @(negedge clk);
            meas = 30'($random(seed));
            meas.power = 10'h300;
            if (s == 1) meas.voltage = 10'h100;
            meas_valid = 1'b1;
            @(negedge clk) meas_valid = 1'b0;
            foreach (cmds[k]) begin
                host.xfer(1'b1, 1'b0, cmds[k], got);
                check(got, pick(s));
            end
            check(result, pick(s));
        end
        print_verdict();
    end
endmodule : smrp_port_tb
